// ### src/adcos_pkg.sv
// Contract
// - Take one sample per sampling clock rise
// - Ten 1.5-bit stages plus one comparator
// - Deskew stage codes, correct into 12 bits
// - Format select low: invert the MSB
// - Format select high: plain offset binary
// - Enable high: all outputs released except slew_limit, which stays driven; conversion continues
// - Enable low: all outputs driven again quickly
// - Slew select limits edges, not data
// - Flag high on all-zero or all-one word
// - Ready strobe is clock image aligned to data
// - Output word changes after clock falling edge
// - Strobe moves half cycle after data
// - Latency 5.5 sampling cycles to output
package adcos_pkg;
  // Pipeline shape
  localparam int STAGES = 11;
  localparam int RES_STAGES = 10;
  localparam int WORD_W = 12;
  localparam int CODE_W = 2 * RES_STAGES + 1;
  // Half-cycle ticks from sampling edge to output update
  localparam int LATENCY_HALF = 11;
  // Deskew depth of stage k is DESKEW_BASE - k ticks
  localparam int DESKEW_BASE = 10;
  // Largest legal 1.5-bit stage code
  localparam logic [1:0] CODE_MAX = 2'h2;
  // Register byte offsets
  localparam logic [3:0] OFF_STATUS = 4'h0;
  localparam logic [3:0] OFF_MASK = 4'h4;
  localparam logic [3:0] OFF_LAST = 4'h8;
  localparam logic [3:0] OFF_COUNT = 4'hC;
  // Status bit positions
  localparam int ST_RANGE = 0;
  localparam int ST_WORD = 1;
  localparam int ST_W = 2;
  // Reset values
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_RST = 12'h000;
endpackage

// ### src/adcos_top.sv
// The APB register port and the address map were left to the implementer.
`timescale 1ns/1ns
module adcos_top #(
  parameter int WORD_W = adcos_pkg::WORD_W
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Sampling clock pin and analog stage comparator codes
  input wire logic sample_clk,
  input wire logic [adcos_pkg::CODE_W-1:0] stage_codes,
  // Control pins
  input wire logic format_select_n,
  input wire logic output_enable_n,
  input wire logic slew_limit_select,
  // Output pins, each but slew_limit with its enable
  output logic [WORD_W-1:0] sample_word,
  output logic sample_word_oe,
  output logic out_of_range,
  output logic out_of_range_oe,
  output logic sample_valid_strobe,
  output logic sample_valid_strobe_oe,
  output logic slew_limit
);

  // Clamp an illegal stage code to the top of the redundant range
  function automatic logic [1:0] clamp_code(input logic [1:0] c);
    clamp_code = (c > adcos_pkg::CODE_MAX) ? adcos_pkg::CODE_MAX : c;
  endfunction

  // Redundant sum: each stage weighs twice the next, comparator is LSB
  function automatic logic [WORD_W-1:0] correct(
    input logic [2*adcos_pkg::RES_STAGES-1:0] res,
    input logic last
  );
    logic [WORD_W:0] acc;
    acc = {{WORD_W{1'b0}}, last};
    for (int k = 0; k < adcos_pkg::RES_STAGES; k++) begin
      acc = acc + ({{(WORD_W-1){1'b0}}, clamp_code(res[2*k +: 2])}
            << (adcos_pkg::RES_STAGES - k));
    end
    correct = acc[WORD_W-1:0];
  endfunction

  // Two-flop synchronisers for every pin input
  // The stage codes cross as a plain bus: the converter core holds them
  // steady for a half sample period, far longer than two flops need.
  logic sclk_m_q, sclk_s_q;
  logic oen_m_q, oen_s_q;
  logic fmt_m_q, fmt_s_q;
  logic slew_m_q, slew_s_q;
  logic [adcos_pkg::CODE_W-1:0] code_m_q, code_s_q;

  // Synchroniser chain; first flops feed only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_m_q <= 1'b0;
      sclk_s_q <= 1'b0;
      oen_m_q <= 1'b1;
      oen_s_q <= 1'b1;
      fmt_m_q <= 1'b1;
      fmt_s_q <= 1'b1;
      slew_m_q <= 1'b0;
      slew_s_q <= 1'b0;
      code_m_q <= '0;
      code_s_q <= '0;
    end else begin
      sclk_m_q <= sample_clk;
      sclk_s_q <= sclk_m_q;
      oen_m_q <= output_enable_n;
      oen_s_q <= oen_m_q;
      fmt_m_q <= format_select_n;
      fmt_s_q <= fmt_m_q;
      slew_m_q <= slew_limit_select;
      slew_s_q <= slew_m_q;
      code_m_q <= stage_codes;
      code_s_q <= code_m_q;
    end
  end

  // Delayed clock copy doubles as the ready strobe
  logic strobe_q;
  wire rise_tick = sclk_s_q & ~strobe_q; // Sampling edge seen
  wire fall_tick = ~sclk_s_q & strobe_q; // Output edge seen
  wire half_tick = rise_tick | fall_tick;

  // Deskew delay lines, one per resolving stage, clocked on half ticks.
  // Stages work on alternating phases, so stage k of a sample lands
  // k half cycles after its sampling edge.
  logic [1:0] dly_q [adcos_pkg::RES_STAGES][adcos_pkg::DESKEW_BASE];
  logic [2*adcos_pkg::RES_STAGES-1:0] aligned;

  // Tap of stage k sits DESKEW_BASE-k ticks behind its input
  always_comb begin
    aligned = '0;
    for (int k = 0; k < adcos_pkg::RES_STAGES; k++) begin
      aligned[2*k +: 2] = dly_q[k][adcos_pkg::DESKEW_BASE-1-k];
    end
  end

  // Shift every line on each half tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < adcos_pkg::RES_STAGES; k++) begin
        for (int j = 0; j < adcos_pkg::DESKEW_BASE; j++) begin
          dly_q[k][j] <= 2'h0;
        end
      end
    end else if (half_tick) begin
      for (int k = 0; k < adcos_pkg::RES_STAGES; k++) begin
        dly_q[k][0] <= code_s_q[2*k +: 2];
        for (int j = 1; j < adcos_pkg::DESKEW_BASE; j++) begin
          dly_q[k][j] <= dly_q[k][j-1];
        end
      end
    end
  end

  // Comparator stage is the last, so it needs no delay
  wire last_bit = code_s_q[adcos_pkg::CODE_W-1];
  wire [WORD_W-1:0] corr_d = correct(aligned, last_bit);
  wire range_d = (&corr_d) | ~(|corr_d); // Full-scale

  // Corrected word, captured when a sampling edge completes it
  logic [WORD_W-1:0] corr_q;
  logic range_q;

  // One word per sampling clock rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      corr_q <= adcos_pkg::WORD_RST;
      range_q <= 1'b0;
    end else if (rise_tick) begin
      corr_q <= corr_d;
      range_q <= range_d; // Flag rides with its word
    end
  end

  // Output stage registers
  logic [WORD_W-1:0] word_q;
  logic oor_q;
  logic word_oe_q, oor_oe_q, strobe_oe_q;
  logic slew_q;
  // Coding: MSB inverted for two's complement
  wire fmt_msb = corr_q[WORD_W-1] ^ ~fmt_s_q;

  // Word and flag change together after the falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_q <= adcos_pkg::WORD_RST;
      oor_q <= 1'b0;
    end else if (fall_tick) begin
      word_q <= {fmt_msb, corr_q[WORD_W-2:0]};
      oor_q <= range_q;
    end
  end

  // Strobe is the clock image, half a cycle behind data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= sclk_s_q;
    end
  end

  // Enables follow the pin; conversion above never stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_oe_q <= 1'b0;
      oor_oe_q <= 1'b0;
      strobe_oe_q <= 1'b0;
      slew_q <= 1'b0;
    end else begin
      word_oe_q <= ~oen_s_q;
      oor_oe_q <= ~oen_s_q;
      strobe_oe_q <= ~oen_s_q;
      slew_q <= slew_s_q; // Drive strength only
    end
  end

  // APB decode
  logic [adcos_pkg::ST_W-1:0] status_q, mask_q;
  logic [31:0] count_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, irq_q;
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire [3:0] off = paddr[3:0];
  wire hit_status = (off == adcos_pkg::OFF_STATUS);
  wire hit_mask = (off == adcos_pkg::OFF_MASK);
  wire hit_last = (off == adcos_pkg::OFF_LAST);
  wire hit_count = (off == adcos_pkg::OFF_COUNT);
  wire mapped = (paddr[31:4] == 28'h0000000) &
                (hit_status | hit_mask | hit_last | hit_count);
  wire wr_ok = access & pwrite & mapped;
  wire [31:0] rd_mux =
    hit_status ? {30'h0, status_q} :
    hit_mask ? {30'h0, mask_q} :
    hit_last ? {19'h0, oor_q, word_q} :
    hit_count ? count_q : 32'h0000_0000;

  // Events and sticky status; a new event beats a clear
  wire [adcos_pkg::ST_W-1:0] events = {fall_tick, fall_tick & range_q};
  wire [adcos_pkg::ST_W-1:0] clr =
    (wr_ok & hit_status) ? pwdata[adcos_pkg::ST_W-1:0] : 2'h0;
  wire [adcos_pkg::ST_W-1:0] status_d = (status_q & ~clr) | events;

  // Answer one cycle after setup; no wait states
  // Read data is taken at setup, so a read that meets a new event shows
  // the state before it; the event itself stays set for the next read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= (setup & ~pwrite & mapped) ? rd_mux : 32'h0000_0000;
    end
  end

  // Software registers, sample counter and interrupt level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= adcos_pkg::STATUS_RST;
      mask_q <= adcos_pkg::MASK_RST;
      count_q <= adcos_pkg::COUNT_RST;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      if (wr_ok & hit_mask) begin
        mask_q <= pwdata[adcos_pkg::ST_W-1:0];
      end
      if (wr_ok & hit_count) begin
        count_q <= adcos_pkg::COUNT_RST;
      end else if (rise_tick) begin
        count_q <= count_q + 32'h0000_0001;
      end
      irq_q <= |(status_d & mask_q);
    end
  end

  // Ports straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign sample_word = word_q;
  assign sample_word_oe = word_oe_q;
  assign out_of_range = oor_q;
  assign out_of_range_oe = oor_oe_q;
  assign sample_valid_strobe = strobe_q;
  assign sample_valid_strobe_oe = strobe_oe_q;
  assign slew_limit = slew_q;

  // Checks beside the logic. Several restate local timing on purpose:
  // they pin down the phase relations that the output pins promise.

  a_word_format: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(fall_tick) |-> word_q == {$past(corr_q[WORD_W-1]) ^
      ~$past(fmt_s_q), $past(corr_q[WORD_W-2:0])})
    else $error("Output word coding wrong");

  // Flag judged against the raw word that the pins carry
  a_range_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(fall_tick) |-> oor_q == (
      (&{word_q[WORD_W-1] ^ ~$past(fmt_s_q), word_q[WORD_W-2:0]}) |
      ~(|{word_q[WORD_W-1] ^ ~$past(fmt_s_q), word_q[WORD_W-2:0]})))
    else $error("Range flag disagrees with word");

  a_flag_with_word: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(oor_q) |-> $past(fall_tick))
    else $error("Flag moved off the word update");

  a_word_at_fall: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(word_q) |-> $past(fall_tick) && !strobe_q)
    else $error("Word changed outside falling edge");

  // Word and flag stand still for as long as the strobe is high
  a_data_stands: assert property (
    @(posedge pclk) disable iff (!presetn)
    strobe_q |-> $stable(word_q) && $stable(oor_q))
    else $error("Data moved while strobe high");

  a_strobe_image: assert property (
    @(posedge pclk) disable iff (!presetn)
    strobe_q == $past(sclk_s_q))
    else $error("Strobe is not the clock image");

  a_oe_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    oen_s_q |=> !word_oe_q && !oor_oe_q && !strobe_oe_q)
    else $error("Outputs driven while disabled");

  a_oe_drive: assert property (
    @(posedge pclk) disable iff (!presetn)
    !oen_s_q |=> word_oe_q && oor_oe_q && strobe_oe_q)
    else $error("Outputs not driven while enabled");

  a_slew_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(slew_q) && !$past(fall_tick) |-> $stable(word_q))
    else $error("Slew change disturbed data");

  a_one_per_rise: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise_tick |=> !rise_tick)
    else $error("Two sampling edges back to back");

  // Sample counter steps once per sampling edge unless software clears it
  a_count_step: assert property (
    @(posedge pclk) disable iff (!presetn)
    rise_tick && !(wr_ok && hit_count) |=>
      count_q == $past(count_q) + 32'h0000_0001)
    else $error("Sample count missed an edge");

  // A word event is never lost to a clear in the same cycle
  a_event_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    fall_tick |=> status_q[adcos_pkg::ST_WORD])
    else $error("Word event lost");

  a_comp_direct: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(rise_tick) |-> corr_q[0] ==
      ($past(last_bit) ^ 1'b0))
    else $error("Comparator bit not in LSB");

endmodule

// ### tb/adcos_capture.sv
`timescale 1ns/1ns
// Receiver logic sitting on the converter's output pins
module adcos_capture (
  input wire logic pclk,
  input wire logic [11:0] word,
  input wire logic word_oe,
  input wire logic oor,
  input wire logic oor_oe,
  input wire logic strobe,
  input wire logic strobe_oe,
  output logic [11:0] cap_word,
  output logic cap_oor
);
  logic [13:0] held_q = 14'h0000; // Last level each pin was driven to
  logic [13:0] pins; // Pin levels as this receiver sees them
  logic strobe_q = 1'b0; // Strobe level one cycle back
  // A released pin floats to the inverse of its last driven level,
  // so a stale word never passes for a fresh one
  assign pins[11:0] = word_oe ? word : ~held_q[11:0];
  assign pins[12] = oor_oe ? oor : ~held_q[12];
  assign pins[13] = strobe_oe ? strobe : ~held_q[13];
  // Capture on the strobe rise, not on own timing
  always @(posedge pclk) begin
    if (word_oe) begin
      held_q[11:0] <= word;
    end
    if (oor_oe) begin
      held_q[12] <= oor;
    end
    if (strobe_oe) begin
      held_q[13] <= strobe;
    end
    strobe_q <= pins[13];
    if (pins[13] && !strobe_q) begin
      cap_word <= pins[11:0];
      cap_oor <= pins[12];
    end
  end
endmodule

// ### tb/pipelined_adc_output_stage_tb.sv
`timescale 1ns/1ns
module pipelined_adc_output_stage_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err;
  logic sample_clk = 1'b0;
  logic run_clk = 1'b0; // Gates the sampling clock
  logic [20:0] codes = 21'h000000; // Stage codes, held per test
  logic fmt_n = 1'b1;
  logic oe_n = 1'b0;
  logic slew = 1'b0;
  logic [11:0] word, cap_word, ex;
  logic word_oe, oor, oor_oe, strobe, strobe_oe, slew_q, cap_oor;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  // Codes per test: zero, clamped max, mid, lsb, ones, twos
  logic [20:0] tbl [6] = '{21'h000000, 21'h1FFFFF, 21'h000002,
    21'h100000, 21'h055555, 21'h0AAAAA};

  adcos_top #(.WORD_W(12)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sample_clk(sample_clk),
    .stage_codes(codes), .format_select_n(fmt_n),
    .output_enable_n(oe_n), .slew_limit_select(slew),
    .sample_word(word), .sample_word_oe(word_oe), .out_of_range(oor),
    .out_of_range_oe(oor_oe), .sample_valid_strobe(strobe),
    .sample_valid_strobe_oe(strobe_oe), .slew_limit(slew_q));
  adcos_capture rx (.pclk(pclk), .word(word), .word_oe(word_oe),
    .oor(oor), .oor_oe(oor_oe), .strobe(strobe),
    .strobe_oe(strobe_oe), .cap_word(cap_word), .cap_oor(cap_oor));

  // System clock, 50 MHz
  initial forever #10 pclk = ~pclk;
  // Sampling clock, 160 ns, phase unrelated; stops low when gated
  initial begin
    #7;
    forever #80 sample_clk = run_clk & ~sample_clk;
  end
  // Hang guard, far above the expected run length
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic wr, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench's cycle guard ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Expected word from held codes; code 3 counts as 2
  function automatic logic [11:0] raw_word(input logic [20:0] c);
    logic [11:0] s;
    logic [1:0] k2;
    s = {11'h000, c[20]};
    for (int k = 0; k < 10; k++) begin
      k2 = (c[2*k+:2] == 2'h3) ? 2'h2 : c[2*k+:2];
      s = s + ({10'h000, k2} << (10 - k));
    end
    return s;
  endfunction

  // Word values, both codings, range flag, slew pin
  task automatic t_words();
    for (int i = 0; i < 6; i++) begin
      @(posedge pclk);
      codes <= tbl[i];
      fmt_n <= ~i[0];
      slew <= i[1];
      run_clk <= 1'b1;
      settle(130);
      ex = raw_word(tbl[i]);
      chk(32'(cap_oor), 32'(ex == 12'h000 || ex == 12'hFFF));
      chk(32'(cap_word), 32'({ex[11] ^ ~fmt_n, ex[10:0]}));
      chk(32'(slew_q), 32'(slew));
    end
    $display("test words done");
  endtask
  // Sample count, sticky events, mask and interrupt
  task automatic t_irq();
    @(posedge pclk);
    run_clk <= 1'b0;
    codes <= 21'h000000;
    settle(20);
    apb(1'b1, 32'h0000_000C, 32'h0000_0000);
    apb(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, 32'h0000_0000, 32'h0000_0003);
    apb(1'b1, 32'h0000_0004, 32'h0000_0002);
    settle(3);
    chk(32'(irq), 32'h0000_0000);
    run_clk <= 1'b1;
    settle(64);
    run_clk <= 1'b0;
    settle(20);
    apb(1'b0, 32'h0000_000C, 32'h0000_0000);
    chk(rd, 32'h0000_0008);
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, 32'h0000_0000, 32'h0000_0002);
    settle(3);
    chk(32'(irq), 32'h0000_0000);
    $display("test irq done");
  endtask
  // Release pins while converting, then drive again
  task automatic t_oe();
    @(posedge pclk);
    run_clk <= 1'b1;
    codes <= 21'h000002;
    fmt_n <= 1'b1;
    oe_n <= 1'b1;
    settle(130);
    chk(32'({word_oe, oor_oe, strobe_oe}), 32'h0000_0000);
    oe_n <= 1'b0;
    settle(5);
    chk(32'({word_oe, oor_oe, strobe_oe}), 32'h0000_0007);
    settle(30);
    chk(32'(cap_word), 32'h0000_0800);
    $display("test oe done");
  endtask
  // Reset values and an unmapped address
  task automatic t_regs();
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 32'(a), 32'h0000_0000);
      chk(rd, 32'h0000_0000);
    end
    apb(1'b0, 32'h0000_0010, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    $display("test regs done");
  endtask

  task automatic close_out();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    settle(20);
    presetn <= 1'b1;
    t_regs();
    t_words();
    t_irq();
    t_oe();
    close_out();
  end
endmodule
